// [core/fpm_pkg.sv]
package fpm_pkg;

    // Duty code width; code 0 is fully off, full scale is fully on.
    localparam int DUTY_W = 8;
    localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hFF;

    // Clock rate and PWM repetition rate.
    localparam int CLK_HZ = 100_000_000;
    localparam int PWM_HZ = 30;
    // Clock cycles per PWM step so that DUTY_FULL steps make one period.
    localparam int PRESCALE_CYC = CLK_HZ / (PWM_HZ * 255);

    // Interval lengths counted in whole PWM periods, and the recovery pulse count.
    localparam int STARTUP_PERIODS = 32;
    localparam int MISS_PERIODS    = 32;
    localparam int DIAG_PERIODS    = 3;
    localparam int RECOVER_PERIODS = 32;
    localparam int RECOVER_PULSES  = 16;

    // Tach blanking after drive turn-on.
    localparam int BLANK_NS  = 3000;
    localparam int CLK_NS    = 10;
    localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;

    // Default digital thresholds for the level inputs.
    localparam logic [DUTY_W-1:0] OVERTEMP_THRESHOLD = 8'hFF;
    localparam logic [DUTY_W-1:0] SHUTDOWN_THRESHOLD = 8'h00;

    typedef enum logic [2:0] {
        FPM_SHUTDOWN,
        FPM_STARTUP1,
        FPM_STARTUP2,
        FPM_RUN,
        FPM_DIAG,
        FPM_FAULT
    } fpm_state_t;

    // Levels presented to the controller.
    typedef struct packed {
        logic [DUTY_W-1:0] temp;
        logic [DUTY_W-1:0] min_speed;
    } fpm_levels_t;

endpackage

// [core/fpm_tach_sync.sv]
`timescale 1ns/10ps
`default_nettype none
// Three-stage synchroniser with agreement filter and rising-edge pulse.
module fpm_tach_sync (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic clk_en,
    input  wire logic async_in,
    output logic      rise_pulse
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic level_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else if (clk_en) begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // A change counts only once the second and third stage agree.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            level_ff <= 1'b0;
        end else if (clk_en && (s2_ff == s3_ff)) begin
            level_ff <= s3_ff;
        end
    end

    assign rise_pulse = clk_en && (s2_ff == s3_ff) && s3_ff && !level_ff; // R19
endmodule
`default_nettype wire

// [core/fpm_fan_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1: Fault shown by driving alarm low; pin is only pulled low or released.
// R2: Fan-fault alarm holds until 16 tach pulses arrive in one 32-period window.
// R3: Over-temperature variant also alarms when temperature level reaches its threshold.
// R4: During a fan fault the drive output stays continuously high.
// R5: Nothing latches; monitoring continues and PWM resumes when the fan recovers.
// R6: Speed is set only by duty; the period is fixed.
// R7: Duty spans fully off to fully on inclusive.
// R8: Default period gives a 30 Hz repetition rate.
// R9: Active duty is the greater of temperature and minimum-speed levels.
// R10: Drive output is active high.
// R11: After reset or leaving shutdown, drive high for 32 periods first.
// R12: Tach pulses seen during start-up lead to normal PWM afterwards.
// R13: No pulses during start-up restarts the start-up interval once.
// R14: No pulses in the second start-up interval raises the fan-fault alarm.
// R15: Minimum-speed level at shutdown threshold: drive low, alarm released.
// R16: In normal PWM, 32 periods without a tach pulse flag a fan problem.
// R17: Tach pulses within 3.0 us after drive turn-on are ignored.
// R18: Levels are digital duty codes compared with a free-running period counter.
// R19: Tach input is synchronised and each rising edge counts as a pulse.
// R20: A prescaler makes the PWM tick; all intervals count whole PWM periods.
module fpm_fan_ctrl #(
    parameter int OVERTEMP_EN  = 1,
    parameter int PRESCALE_CYC = fpm_pkg::PRESCALE_CYC
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  clk_en,
    input  wire fpm_pkg::fpm_levels_t  levels_in,
    input  wire logic [7:0]            overtemp_threshold,
    input  wire logic [7:0]            shutdown_threshold,
    input  wire logic                  tach_in,
    output logic                       fan_drive_out,
    output logic                       alarm_n_out,
    output logic                       alarm_n_oe,
    output fpm_pkg::fpm_state_t        state_out
);
    localparam int PW = $clog2(PRESCALE_CYC + 1);
    localparam int BW = $clog2(fpm_pkg::BLANK_CYC + 1);

    fpm_pkg::fpm_state_t state_ff;
    fpm_pkg::fpm_state_t nxt_state;
    logic [PW-1:0]       pre_cnt_ff;
    logic [7:0]          ramp_ff;
    logic [5:0]          per_cnt_ff;
    logic [4:0]          pulse_cnt_ff;
    logic                seen_ff;
    logic [BW-1:0]       blank_cnt_ff;
    logic                drive_ff;
    logic                alarm_ff;
    logic                tach_rise;
    logic                tach_ok;
    logic                step_tick;
    logic                period_tick;
    logic [7:0]          duty;
    logic                pwm_level;
    logic                shutdown_req;
    logic                overtemp;
    logic                nxt_drive;
    logic                interval_done;

    fpm_tach_sync u_sync (
        .clock      (clock),
        .rst        (rst),
        .clk_en     (clk_en),
        .async_in   (tach_in),
        .rise_pulse (tach_rise)
    );

    // Prescaler: one step per PRESCALE_CYC clocks, 255 steps per period.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pre_cnt_ff <= '0;
        end else if (clk_en) begin
            if (pre_cnt_ff == PW'(PRESCALE_CYC - 1)) begin // R20
                pre_cnt_ff <= '0;
            end else begin
                pre_cnt_ff <= pre_cnt_ff + 1'b1;
            end
        end
    end
    assign step_tick = clk_en && (pre_cnt_ff == PW'(PRESCALE_CYC - 1));

    // Free-running ramp 0..254 sets a fixed period regardless of duty.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ramp_ff <= '0;
        end else if (step_tick) begin
            ramp_ff <= (ramp_ff == 8'hFE) ? 8'h00 : ramp_ff + 8'h01; // R6 R8
        end
    end
    assign period_tick = step_tick && (ramp_ff == 8'hFE); // R20

    assign duty = (levels_in.temp > levels_in.min_speed) ? levels_in.temp
                                                         : levels_in.min_speed; // R9
    // Code 0 never drives, code FF drives the whole period.
    assign pwm_level = (ramp_ff < duty); // R7 R18
    assign shutdown_req = (levels_in.min_speed <= shutdown_threshold); // R15
    assign overtemp = (OVERTEMP_EN != 0) && (levels_in.temp >= overtemp_threshold); // R3

    assign tach_ok = tach_rise && (blank_cnt_ff == '0); // R17

    // Blanking counter restarts on each drive turn-on.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            blank_cnt_ff <= '0;
        end else if (clk_en) begin
            if (nxt_drive && !drive_ff) begin
                blank_cnt_ff <= BW'(fpm_pkg::BLANK_CYC); // R17
            end else if (blank_cnt_ff != '0) begin
                blank_cnt_ff <= blank_cnt_ff - 1'b1;
            end
        end
    end

    always_comb begin
        case (state_ff)
            fpm_pkg::FPM_STARTUP1,
            fpm_pkg::FPM_STARTUP2: interval_done = (per_cnt_ff == 6'(fpm_pkg::STARTUP_PERIODS - 1));
            fpm_pkg::FPM_DIAG:     interval_done = (per_cnt_ff == 6'(fpm_pkg::DIAG_PERIODS - 1));
            fpm_pkg::FPM_RUN:      interval_done = (per_cnt_ff == 6'(fpm_pkg::MISS_PERIODS - 1));
            default:               interval_done = (per_cnt_ff == 6'(fpm_pkg::RECOVER_PERIODS - 1));
        endcase
        interval_done = interval_done && period_tick;
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            fpm_pkg::FPM_SHUTDOWN: begin
                nxt_state = fpm_pkg::FPM_STARTUP1; // R11
            end
            fpm_pkg::FPM_STARTUP1: begin
                if (interval_done) begin
                    nxt_state = (seen_ff || tach_ok) ? fpm_pkg::FPM_RUN : fpm_pkg::FPM_STARTUP2; // R12 R13
                end
            end
            fpm_pkg::FPM_STARTUP2: begin
                if (interval_done) begin
                    nxt_state = (seen_ff || tach_ok) ? fpm_pkg::FPM_RUN : fpm_pkg::FPM_FAULT; // R14
                end
            end
            fpm_pkg::FPM_RUN: begin
                if (interval_done && !seen_ff && !tach_ok) begin
                    nxt_state = fpm_pkg::FPM_DIAG; // R16
                end
            end
            fpm_pkg::FPM_DIAG: begin
                if (seen_ff || tach_ok) begin
                    nxt_state = fpm_pkg::FPM_RUN;
                end else if (interval_done) begin
                    nxt_state = fpm_pkg::FPM_STARTUP2;
                end
            end
            fpm_pkg::FPM_FAULT: begin
                // Recovery needs the pulse count inside one window.
                if (interval_done &&
                    ({1'b0, pulse_cnt_ff} + {5'd0, tach_ok} >= 6'(fpm_pkg::RECOVER_PULSES))) begin
                    nxt_state = fpm_pkg::FPM_RUN; // R2 R5
                end
            end
            default: nxt_state = fpm_pkg::FPM_SHUTDOWN;
        endcase
        if (shutdown_req) begin
            nxt_state = fpm_pkg::FPM_SHUTDOWN; // R15
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= fpm_pkg::FPM_SHUTDOWN;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // Period counter and pulse tracking restart on every state change.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            per_cnt_ff   <= '0;
            seen_ff      <= 1'b0;
            pulse_cnt_ff <= '0;
        end else if (clk_en) begin
            if (nxt_state != state_ff || interval_done) begin
                per_cnt_ff   <= '0;
                seen_ff      <= 1'b0;
                pulse_cnt_ff <= '0;
            end else begin
                if (period_tick) begin
                    per_cnt_ff <= per_cnt_ff + 6'd1; // R20
                end
                if (tach_ok) begin
                    seen_ff <= 1'b1;
                    if (pulse_cnt_ff != 5'h1F) begin
                        pulse_cnt_ff <= pulse_cnt_ff + 5'd1; // R2
                    end
                end
            end
        end
    end

    always_comb begin
        case (nxt_state)
            fpm_pkg::FPM_SHUTDOWN: nxt_drive = 1'b0; // R15
            fpm_pkg::FPM_RUN:      nxt_drive = pwm_level; // R10
            default:               nxt_drive = 1'b1; // R4 R11
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            drive_ff <= 1'b0;
            alarm_ff <= 1'b0;
        end else if (clk_en) begin
            drive_ff <= nxt_drive;
            alarm_ff <= (nxt_state == fpm_pkg::FPM_FAULT) ||
                        (overtemp && nxt_state != fpm_pkg::FPM_SHUTDOWN); // R1 R3 R5
        end
    end

    // Alarm is open drain: its line is only ever pulled low or released.
    assign fan_drive_out = drive_ff;
    assign alarm_n_out   = 1'b0; // R1
    assign alarm_n_oe    = alarm_ff;
    assign state_out     = state_ff;

endmodule
`default_nettype wire

// [bench/fpm_fan_ctrl_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module fpm_fan_ctrl_chk #(
    parameter int OVERTEMP_EN  = 1,
    parameter int PRESCALE_CYC = 1
) (
    input wire logic                 clock,
    input wire logic                 rst,
    input wire logic                 clk_en,
    input wire fpm_pkg::fpm_levels_t levels_in,
    input wire logic [7:0]           overtemp_threshold,
    input wire logic [7:0]           shutdown_threshold,
    input wire logic                 tach_in,
    input wire logic                 fan_drive_out,
    input wire logic                 alarm_n_out,
    input wire logic                 alarm_n_oe,
    input wire fpm_pkg::fpm_state_t  state_out
);
    localparam int PER  = 255 * PRESCALE_CYC;
    // The first interval may start mid-period, so the windows allow one period of slack.
    localparam int LO32 = 31 * PER - 4;
    localparam int HI32 = 33 * PER;
    localparam int LO3  = 2 * PER - 4;
    localparam int HI3  = 4 * PER;
    fpm_pkg::fpm_state_t st_ff;
    int                  dwell_ff;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff <= fpm_pkg::FPM_SHUTDOWN;
            dwell_ff <= 0;
        end else begin
            st_ff <= state_out;
            dwell_ff <= (state_out != st_ff) ? 0 : dwell_ff + 1;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence s_left(fpm_pkg::fpm_state_t from);
        st_ff == from && state_out != st_ff && state_out != fpm_pkg::FPM_SHUTDOWN;
    endsequence
    sequence s_fault2;
        (state_out == fpm_pkg::FPM_FAULT) [*2];
    endsequence
    AST_OD_LOW: assert property (alarm_n_out == 1'b0) else $error("alarm data not low");
    AST_FAULT_DRIVE: assert property (s_fault2 |-> fan_drive_out) else $error("drive low in fault");
    AST_FAULT_ALARM: assert property (s_fault2 |-> alarm_n_oe) else $error("alarm off in fault");
    AST_FAULT_EXIT: assert property (s_left(fpm_pkg::FPM_FAULT) |-> state_out == fpm_pkg::FPM_RUN)
        else $error("fault left wrongly");
    AST_ST1_LEN: assert property (s_left(fpm_pkg::FPM_STARTUP1) |-> dwell_ff inside {[LO32:HI32]})
        else $error("first start-up length");
    AST_ST2_LEN: assert property (s_left(fpm_pkg::FPM_STARTUP2) |-> dwell_ff inside {[LO32:HI32]})
        else $error("second start-up length");
    AST_RUN_MISS: assert property (s_left(fpm_pkg::FPM_RUN) |-> state_out == fpm_pkg::FPM_DIAG && dwell_ff >= LO32)
        else $error("early missing-pulse exit");
    AST_DIAG_LEN: assert property (s_left(fpm_pkg::FPM_DIAG) |-> state_out == fpm_pkg::FPM_RUN ||
        dwell_ff inside {[LO3:HI3]}) else $error("diagnostic length");
    AST_FULL_ON: assert property ((state_out inside {fpm_pkg::FPM_STARTUP1, fpm_pkg::FPM_STARTUP2}) [*2]
        |-> fan_drive_out) else $error("start-up drive low");
    AST_WAKE: assert property (st_ff == fpm_pkg::FPM_SHUTDOWN && state_out != st_ff |->
        state_out == fpm_pkg::FPM_STARTUP1 ##1 fan_drive_out) else $error("wake not start-up");
    AST_SHDN: assert property ((levels_in.min_speed <= shutdown_threshold) [*4] |->
        state_out == fpm_pkg::FPM_SHUTDOWN && !fan_drive_out && !alarm_n_oe) else $error("shutdown");
    AST_FULL_DUTY: assert property ((state_out == fpm_pkg::FPM_RUN &&
        (levels_in.temp == 8'hFF || levels_in.min_speed == 8'hFF)) [*3] |-> fan_drive_out) else $error("full duty");
    AST_OVERTEMP: assert property ((OVERTEMP_EN != 0 && state_out != fpm_pkg::FPM_SHUTDOWN &&
        levels_in.temp >= overtemp_threshold) [*3] |-> alarm_n_oe) else $error("overtemp alarm");
endmodule
`default_nettype wire

// [bench/fpm_fan_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Sense pulses appear only while the fan spins and drive current flows, like the real resistor.
module fpm_fan_model (
    input  wire logic clock,
    input  wire logic spin,
    input  wire logic drive,
    output logic      tach
);
    int unsigned ph_ff = 0;
    always_ff @(posedge clock) begin
        ph_ff <= (ph_ff == 199) ? 0 : ph_ff + 1;
    end
    assign tach = spin && drive && (ph_ff < 20);
endmodule
`default_nettype wire

// [bench/tb_fan_pwm_fault_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_fan_pwm_fault_monitor;
    localparam int PSC = 2;
    localparam int PER = 255 * PSC;
    logic                 clock;
    logic                 rst = 1'b1;
    fpm_pkg::fpm_levels_t lv = '{temp: 8'h20, min_speed: 8'hC0};
    logic [7:0]           ot_thr = fpm_pkg::OVERTEMP_THRESHOLD;
    logic [7:0]           sd_thr = fpm_pkg::SHUTDOWN_THRESHOLD;
    logic                 spin = 1'b0;
    logic                 tach;
    logic                 drive;
    logic                 al_n;
    logic                 al_oe;
    fpm_pkg::fpm_state_t  st;
    int                   mismatches = 0;
    int                   n_compared = 0;
    int                   cyc = 0;
    fpm_fan_ctrl #(.OVERTEMP_EN(1), .PRESCALE_CYC(PSC)) u_dut (.clock(clock), .rst(rst), .clk_en(1'b1),
        .levels_in(lv), .overtemp_threshold(ot_thr), .shutdown_threshold(sd_thr), .tach_in(tach),
        .fan_drive_out(drive), .alarm_n_out(al_n), .alarm_n_oe(al_oe), .state_out(st));
    fpm_fan_model u_fan (.clock(clock), .spin(spin), .drive(drive), .tach(tach));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        // The scenarios need about 90,000 cycles in the worst case.
        if (cyc == 99000) begin
            mismatches++;
            finish_test();
        end
    end
    // Sampling 1 ns after the edge keeps reads clear of the edge's own updates.
    task automatic wait_st(fpm_pkg::fpm_state_t s, int lim);
        int n;
        n = 0;
        while (st !== s && n < lim) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic t_no_start();
        wait_st(fpm_pkg::FPM_STARTUP2, 34 * PER);
        check(st, fpm_pkg::FPM_STARTUP2);
        check(drive, 1'b1);
        wait_st(fpm_pkg::FPM_FAULT, 34 * PER);
        check(st, fpm_pkg::FPM_FAULT);
        settle(2);
        check({drive, al_oe, al_n}, 3'b110);
    endtask
    task automatic t_recover();
        @(posedge clock);
        spin <= 1'b1;
        settle(2000);
        check(st, fpm_pkg::FPM_FAULT);
        wait_st(fpm_pkg::FPM_RUN, 70 * PER);
        check(st, fpm_pkg::FPM_RUN);
        settle(2);
        check(al_oe, 1'b0);
    endtask
    // A window of exactly one period counts the same high time at any phase.
    task automatic t_duty();
        logic [7:0]  tv [4] = '{8'h40, 8'h90, 8'h01, 8'hFF};
        logic [7:0]  mv [4] = '{8'h80, 8'h10, 8'h01, 8'h02};
        logic [15:0] hi;
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            lv <= '{temp: tv[k], min_speed: mv[k]};
            settle(2 * PER);
            hi = 0;
            repeat (PER) begin
                @(posedge clock);
                #1;
                hi += drive;
            end
            check(hi, 16'((tv[k] > mv[k] ? tv[k] : mv[k]) * PSC));
            check(al_oe, tv[k] >= ot_thr);
        end
        @(posedge clock);
        lv <= '{temp: 8'h20, min_speed: 8'hC0};
    endtask
    task automatic t_stall();
        @(posedge clock);
        spin <= 1'b0;
        // Pulses seen before the stall keep the current window alive, so detection can take two windows.
        wait_st(fpm_pkg::FPM_DIAG, 66 * PER);
        check(st, fpm_pkg::FPM_DIAG);
        settle(2);
        check(drive, 1'b1);
        spin <= 1'b1;
        wait_st(fpm_pkg::FPM_RUN, 4 * PER);
        check({st, al_oe}, {fpm_pkg::FPM_RUN, 1'b0});
    endtask
    task automatic t_shutdown();
        @(posedge clock);
        lv <= '{temp: 8'hFF, min_speed: sd_thr};
        settle(6);
        check({st, drive, al_oe}, {fpm_pkg::FPM_SHUTDOWN, 2'b00});
        lv <= '{temp: 8'h20, min_speed: 8'hC0};
        wait_st(fpm_pkg::FPM_STARTUP1, 8);
        settle(2);
        check({st, drive}, {fpm_pkg::FPM_STARTUP1, 1'b1});
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        t_no_start();
        t_recover();
        t_duty();
        t_stall();
        t_shutdown();
        finish_test();
    end
endmodule
bind fpm_fan_ctrl fpm_fan_ctrl_chk #(.OVERTEMP_EN(OVERTEMP_EN), .PRESCALE_CYC(PRESCALE_CYC)) u_chk (
    .clock(clock), .rst(rst), .clk_en(clk_en), .levels_in(levels_in), .overtemp_threshold(overtemp_threshold),
    .shutdown_threshold(shutdown_threshold), .tach_in(tach_in), .fan_drive_out(fan_drive_out),
    .alarm_n_out(alarm_n_out), .alarm_n_oe(alarm_n_oe), .state_out(state_out));
`default_nettype wire
